/* File: logic/olo_pkg.sv */
/*
 * Package for the open-load-at-on diagnosis sequencer: channel count,
 * timing constants and the carrier structs shared by the design.
 * Assumes a 100 MHz system clock.
 */
package olo_pkg;
	localparam int          OLO_CHANNELS     = 8;
	localparam int          OLO_CLK_MHZ      = 100;
	localparam int          OLO_PERIOD_MS    = 160;
	localparam int          OLO_WINDOW_US    = 45;
	localparam int          OLO_WINDOW_CYC   = OLO_WINDOW_US * OLO_CLK_MHZ;
	localparam int          OLO_PERIOD_CYC   = OLO_PERIOD_MS * 1000 * OLO_CLK_MHZ;
	localparam int          OLO_CNT_W        = 25;
	localparam logic [7:0]  OLO_STATUS_RST   = 8'h00;
	localparam logic [7:0]  OLO_REQUEST_RST  = 8'h00;
	localparam logic [24:0] OLO_CNT_ZERO     = 25'h0000000;
	localparam logic [24:0] OLO_CNT_ONE      = 25'h0000001;

	typedef logic [OLO_CHANNELS-1:0] olo_chan_t;

	// request write from the serial command decoder
	typedef struct packed {
		logic      write;
		olo_chan_t data;
	} olo_req_wr_s;

	// per-channel drive towards the output stage
	typedef struct packed {
		olo_chan_t force_off;
		olo_chan_t pullup_en;
	} olo_drive_s;

	typedef enum logic [1:0] {
		OLO_IDLE,
		OLO_WAIT,
		OLO_TEST
	} olo_state_e;
endpackage

/* File: logic/olo_sequencer.sv */
/*
 * Open-load-at-on diagnosis sequencer for eight driver channels.
 * Assumes the serial interface hands over decoded request writes and
 * status reads as one-cycle strobes, and that comparator and fault
 * latch inputs are synchronous to clk_sys.
 */
// Contract
// [RL1] a request bit for a low-side channel is ignored and its request bit stays as it was; the code writes that bit as 0.
// [RL2] the host should not request the test on PWM-driven or inductive loads.
// [RL3] the test runs on one channel at a time and starts when its request bit is set.
// [RL4] while active the channel is switched off once per test period for at most the window.
// [RL5] during the switch-off the pull-up current is enabled and the comparator watched.
// [RL6] a comparator high ends the switch-off at once and turns the channel back on.
// [RL7] comparator still low at window end sets the open-load flag and turns the channel on.
// [RL8] the first switch-off comes one full test period after a request is accepted.
// [RL9] the test repeats each period while the request bit stays set, results per channel.
// [RL10] no test is run on a channel whose overload or overtemperature flag is set.
// [RL11] a request naming more than one channel is not executed and changes nothing.
// [RL12] a request for another channel is only taken once the running cycle is over.
// [RL13] the status holds one bit per channel, 1 meaning open load found.
// [RL14] reading the status register clears its fault bits; the code clears a bit only once a clean test cycle has also finished.
// [RL15] a set bit stays set until a clean test cycle has finished and a read has happened.
// [RL16] the overload flag marks overload or overtemperature and the channel latched off.
// [RL17] period and window come from clock counters with parameter terminal counts.
module olo_sequencer
	import olo_pkg::*;
#(
	parameter int PERIOD_CYC = OLO_PERIOD_CYC,
	parameter int WINDOW_CYC = OLO_WINDOW_CYC
) (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	// serial interface side
	input  wire olo_req_wr_s req_wr,
	input  wire logic        status_rd,
	output logic [7:0]       on_test_request_reg,
	output logic [7:0]       open_load_on_status,
	// channel configuration and state
	input  wire olo_chan_t   low_side_cfg,
	input  wire olo_chan_t   overload_overtemp_flag,
	input  wire olo_chan_t   channel_on,
	input  wire olo_chan_t   source_cmp,
	// output stage drive
	output olo_drive_s       drive,
	output logic             test_busy
);
	olo_state_e        state_reg;
	logic [OLO_CNT_W-1:0] cnt_reg;
	logic [2:0]        chan_reg;
	olo_chan_t         fault_reg;
	olo_chan_t         clean_reg;
	olo_chan_t         read_reg;

	function automatic logic one_hot(input olo_chan_t v);
		return (v != '0) && ((v & (v - 1'b1)) == '0);
	endfunction

	function automatic logic [2:0] enc(input olo_chan_t v);
		logic [2:0] r;
		r = 3'h0;
		for (int i = 0; i < OLO_CHANNELS; i++) begin
			if (v[i])
				r = 3'(i);
		end
		return r;
	endfunction

	olo_chan_t  req_eff;
	logic       req_ok;
	logic       win_end;
	logic       per_end;
	logic       cmp_hit;
	logic       test_done;
	logic       test_fail;

	assign req_eff = req_wr.data & ~low_side_cfg; // [RL1]
	// a zero write stops the test except during OLO_TEST, where it is refused; more than one bit is rejected
	assign req_ok = req_wr.write && (req_eff == '0 || one_hot(req_eff)) // [RL11]
		&& (state_reg != OLO_TEST); // [RL12]
	assign per_end = (cnt_reg == 25'(PERIOD_CYC - 1)); // [RL17]
	assign win_end = (cnt_reg == 25'(WINDOW_CYC - 1)); // [RL17]
	assign cmp_hit = source_cmp[chan_reg];
	assign test_done = (state_reg == OLO_TEST) && (cmp_hit || win_end); // [RL6]
	assign test_fail = (state_reg == OLO_TEST) && !cmp_hit && win_end; // [RL7]

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst)
			on_test_request_reg <= OLO_REQUEST_RST;
		else if (req_ok)
			on_test_request_reg <= req_eff; // [RL3]
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= OLO_IDLE;
			cnt_reg   <= OLO_CNT_ZERO;
			chan_reg  <= 3'h0;
		end else if (req_ok) begin
			// new acceptance restarts the full period
			state_reg <= (req_eff == '0) ? OLO_IDLE : OLO_WAIT; // [RL8]
			cnt_reg   <= OLO_CNT_ZERO;
			chan_reg  <= enc(req_eff);
		end else begin
			unique case (state_reg)
				OLO_IDLE: cnt_reg <= OLO_CNT_ZERO;
				OLO_WAIT: begin
					if (per_end) begin
						cnt_reg <= OLO_CNT_ZERO;
						// skipped when latched off or channel not on
						if (!overload_overtemp_flag[chan_reg] && channel_on[chan_reg])
							state_reg <= OLO_TEST; // [RL10] [RL16]
					end else
						cnt_reg <= cnt_reg + OLO_CNT_ONE;
				end
				OLO_TEST: begin
					if (test_done) begin
						state_reg <= OLO_WAIT; // [RL9]
						cnt_reg   <= OLO_CNT_ZERO;
					end else
						cnt_reg <= cnt_reg + OLO_CNT_ONE;
				end
			endcase
		end
	end

	// the window is part of the period only loosely; period restarts after test
	always_comb begin
		drive.force_off = '0;
		drive.pullup_en = '0;
		if (state_reg == OLO_TEST && !cmp_hit) begin
			drive.force_off[chan_reg] = 1'b1; // [RL4]
			drive.pullup_en[chan_reg] = 1'b1; // [RL5]
		end
	end
	assign test_busy = (state_reg == OLO_TEST);

	// fault clears only after both a clean cycle and a read; set wins
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			fault_reg <= OLO_STATUS_RST;
			clean_reg <= '0;
			read_reg  <= '0;
		end else begin
			for (int i = 0; i < OLO_CHANNELS; i++) begin
				if (test_fail && chan_reg == 3'(i)) begin
					fault_reg[i] <= 1'b1; // [RL7]
					clean_reg[i] <= 1'b0;
					read_reg[i]  <= 1'b0;
				end else if (fault_reg[i]) begin
					if ((clean_reg[i] || (test_done && chan_reg == 3'(i)))
						&& (read_reg[i] || status_rd)) begin
						fault_reg[i] <= 1'b0; // [RL15]
						clean_reg[i] <= 1'b0;
						read_reg[i]  <= 1'b0;
					end else begin
						if (test_done && chan_reg == 3'(i))
							clean_reg[i] <= 1'b1;
						if (status_rd)
							read_reg[i] <= 1'b1; // [RL14]
					end
				end
			end
		end
	end

	assign open_load_on_status = fault_reg; // [RL13]

	// helper for the window bound: test-busy cycles seen so far
	// a delay range would have to span the full default window, so count instead
	logic [OLO_CNT_W-1:0] busy_cnt_reg;

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst)
			busy_cnt_reg <= OLO_CNT_ZERO;
		else if (test_busy)
			busy_cnt_reg <= busy_cnt_reg + OLO_CNT_ONE;
		else
			busy_cnt_reg <= OLO_CNT_ZERO;
	end

	a_window_bound: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RL4]
		busy_cnt_reg <= 25'(WINDOW_CYC))
		else $error("switch-off window too long");
	a_pullup_in_test: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RL5]
		(drive.pullup_en != '0) |-> test_busy && (drive.force_off == drive.pullup_en))
		else $error("pull-up outside test");
	a_cmp_ends_test: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RL6]
		test_busy && cmp_hit && !req_ok |=> !test_busy)
		else $error("comparator did not end test");
	a_fail_sets_flag: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RL7]
		test_fail |=> open_load_on_status[$past(chan_reg)])
		else $error("open load not flagged");
	a_low_side_ign: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RL1]
		1'b1 |=> ((on_test_request_reg & $past(low_side_cfg)
			& ~$past(on_test_request_reg)) == '0))
		else $error("low-side request accepted");
	a_multi_reject: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RL11]
		req_wr.write && req_eff != '0 && !one_hot(req_eff) |=> $stable(on_test_request_reg))
		else $error("multi-channel request executed");
	a_one_channel: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RL3]
		drive.force_off == '0 || one_hot(drive.force_off))
		else $error("more than one channel under test");
	a_no_test_ovl: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RL10]
		state_reg == OLO_WAIT && per_end && !req_ok && overload_overtemp_flag[chan_reg]
		|=> !test_busy)
		else $error("test on latched-off channel");
	a_accept_wait: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RL8]
		req_ok && req_eff != '0 |=> !test_busy [*8])
		else $error("test started before period");
	a_busy_blocks: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RL12]
		test_busy && req_wr.write |=> $stable(on_test_request_reg))
		else $error("request taken during test");
	// a status bit may only fall once a read has been seen
	a_fault_hold: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RL15]
		1'b1 |=> $past(status_rd)
			|| (($past(open_load_on_status) & ~open_load_on_status & ~$past(read_reg)) == '0))
		else $error("open-load bit cleared without a read");
endmodule

/* File: dv/olo_host_model.sv */
/*
 * Host controller model: issues request-register writes and status reads
 * as one-cycle strobes. Assumes clk_sys from the bench, one caller at a time.
 */
module olo_host_model
	import olo_pkg::*;
(
	// clock
	input  wire logic   clk_sys,
	// decoded serial strobes
	output olo_req_wr_s req_wr,
	output logic        status_rd
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		req_wr = '0;
		status_rd = 1'b0;
	end

	// only steady-on resistive loads are ever requested
	task automatic write_req(input olo_chan_t d);
		@(posedge clk_sys);
		req_wr <= {1'b1, d};
		@(posedge clk_sys);
		req_wr <= '0;
	endtask

	task automatic read_status();
		@(posedge clk_sys);
		status_rd <= 1'b1;
		@(posedge clk_sys);
		status_rd <= 1'b0;
	endtask
endmodule

/* File: dv/olo_testbench.sv */
/*
 * Self-checking bench for the open-load-at-on sequencer.
 * Assumes short period and window parameters; the host model drives strobes.
 */
module testbench
	import olo_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int PER = 200;
	localparam int WIN = 20;
	// low side, write data, expected request
	localparam logic [23:0] ROWS[5] = '{24'h000404, 24'h040c08, 24'h000608,
		24'h000000, 24'h808404};
	logic        clk_sys;
	logic        sys_rst;
	olo_req_wr_s req_wr;
	logic        status_rd;
	olo_chan_t   low_side_cfg, ovl_flag, channel_on, source_cmp, request_q, status_q;
	olo_drive_s  drive;
	logic        test_busy;
	int          failures, samples_checked, n;

	olo_host_model host (.clk_sys(clk_sys), .req_wr(req_wr), .status_rd(status_rd));
	olo_sequencer #(.PERIOD_CYC(PER), .WINDOW_CYC(WIN)) uut (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .req_wr(req_wr), .status_rd(status_rd),
		.on_test_request_reg(request_q), .open_load_on_status(status_q),
		.low_side_cfg(low_side_cfg), .overload_overtemp_flag(ovl_flag),
		.channel_on(channel_on), .source_cmp(source_cmp), .drive(drive),
		.test_busy(test_busy));

	task automatic check(input olo_chan_t seen, input olo_chan_t exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic final_report();
		$display("compares %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	// bounded wait for the window flag, cycles left in n
	task automatic wait_busy(input logic want);
		n = 0;
		while (test_busy !== want && n < 2 * PER) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	initial begin
		#100000;
		failures++;
		final_report();
	end

	initial begin
		sys_rst = 1'b1;
		low_side_cfg = 8'h00;
		ovl_flag = 8'h00;
		channel_on = 8'hff;
		source_cmp = 8'h00;
		repeat (10) @(posedge clk_sys);
		sys_rst <= 1'b0;
		#1 check(status_q, 8'h00);
		foreach (ROWS[i]) begin
			@(posedge clk_sys);
			low_side_cfg <= ROWS[i][23:16];
			host.write_req(ROWS[i][15:8]);
			@(posedge clk_sys);
			#1 check(request_q, ROWS[i][7:0]);
		end
		low_side_cfg <= 8'h00;
		host.write_req(8'h04);
		wait_busy(1'b1);
		check(8'(n > PER - 3 && n < PER + 4), 8'h01);
		check(drive.force_off, 8'h04);
		check(drive.pullup_en, 8'h04);
		// a write for another channel mid-window must be refused
		host.write_req(8'h08);
		wait_busy(1'b0);
		check(8'(n >= WIN - 5 && n <= WIN), 8'h01);
		@(posedge clk_sys);
		#1 check(status_q, 8'h04);
		check(request_q, 8'h04);
		source_cmp <= 8'h04;
		wait_busy(1'b1);
		check(8'(n > PER - 3 && n < PER + 4), 8'h01);
		check(drive.force_off, 8'h00);
		wait_busy(1'b0);
		check(8'(n <= 2), 8'h01);
		check(status_q, 8'h04);
		host.read_status();
		@(posedge clk_sys);
		#1 check(status_q, 8'h00);
		ovl_flag <= 8'h04;
		source_cmp <= 8'h00;
		wait_busy(1'b1);
		check({7'h00, test_busy}, 8'h00);
		check(status_q, 8'h00);
		sys_rst <= 1'b1;
		@(posedge clk_sys);
		#1 check(request_q, 8'h00);
		final_report();
	end
endmodule
